// *** cwd_consts.svh ***
// Constants for the cache and TLB way-degrade block
`ifndef CWD_CONSTS_SVH
`define CWD_CONSTS_SVH
`define CWD_L1_WAYS      2
`define CWD_L2_WAYS      4
`define CWD_TLB_WAYS     2
`define CWD_CNT_W        8
`define CWD_THRESH_DEF   8'h10
`define CWD_INTERVAL_NS  1000000
`define CWD_CLK_MHZ      250
`define CWD_INTERVAL_CYC ((`CWD_INTERVAL_NS * `CWD_CLK_MHZ) / 1000)
`define CWD_IDX_W        5
`endif

// *** cwd_l2_sweep_model.sv ***
// Behavioural model of the L2 sweep engine that answers invalidate-all requests
`timescale 1ns/100ps

module cwd_l2_sweep_model #(
  parameter int SWEEP_CYC = 12
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Sweep handshake
  input  wire logic l2_inval_all,
  output logic      l2_inval_done
);
  // ****************************************
  // Sweep timing
  // ****************************************
  int cnt_reg;

  // A long sweep shows that the block waits for done before retiring a way
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg       <= 0;
      l2_inval_done <= 1'b0;
    end else begin
      l2_inval_done <= (cnt_reg == 1);  // One-cycle done pulse
      if (l2_inval_all) begin
        cnt_reg <= SWEEP_CYC;
      end else if (cnt_reg != 0) begin
        cnt_reg <= cnt_reg - 1;
      end
    end
  end
endmodule // cwd_l2_sweep_model

// *** cwd_pkg.sv ***
// Types for the cache and TLB way-degrade block
package cwd_pkg;
  typedef enum logic [1:0] {
    CWD_L2_IDLE = 2'b00,
    CWD_L2_PEND = 2'b01,
    CWD_L2_RUN  = 2'b11
  } cwd_l2_state_t;
endpackage

// *** cwd_way_degrade.sv ***
// Way-degrade fault tolerance for L1 caches, L2 cache and TLBs
//
// Function
// - Count L1 instr and data cache errors per way, tag and data classes summed.
// - Count L2 tag CE/UE, data CE and raw data UE per way.
// - Reduction condition when a way's count in an interval exceeds threshold.
// - L1 instr reduction with one way left enters halted error state.
// - Else invalidate instr way, never refill, set way-degrade flag.
// - L1 data reduction with one way left enters halted error state.
// - Else invalidate data way with dirty writeback, stop refill, set flag.
// - Defer bit low: L2 reduction starts at once.
// - Defer bit high: L2 reduction waits until software clears the bit.
// - Last L2 way: invalidate all, keep way available, set flag.
// - Else invalidate all available L2 ways, retire way W, set flag.
// - TLB tags and data carry parity; fully-assoc lock bit is majority voted.
// - Diagnostic read of data TLB with parity error demaps and sets urgent bit.
// - Diagnostic read of instr TLB with parity error demaps and sets urgent bit.
// - Set-assoc TLB translation parity error demaps silently.
// - Fully-assoc tag parity error never matches, even when locked.
// - Fully-assoc data parity checked only on tag match.
// - Instr fully-assoc data parity error raises precise fault with entry index.
// - Data fully-assoc data parity error raises precise fault with entry index.
// - Count set-assoc TLB parity errors per way against threshold.
// - TLB reduction with one way left reactivates the earlier reduced way.
// - Then invalidate TLB way W, never refill, set way-degrade flag.
`timescale 1ns/100ps
`include "cwd_consts.svh"

module cwd_way_degrade
  import cwd_pkg::*;
#(
  parameter int                  CNT_W        = `CWD_CNT_W,
  parameter logic [CNT_W-1:0]    THRESHOLD    = `CWD_THRESH_DEF,
  parameter int                  INTERVAL_CYC = `CWD_INTERVAL_CYC,
  parameter int                  FA_ENTRIES   = 32
) (
  // Clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // L1 instr cache error events, one bit per way
  input  wire logic [1:0]               il1_tag_perr,
  input  wire logic [1:0]               il1_data_perr,
  // L1 data cache error events
  input  wire logic [1:0]               dl1_tag_perr,
  input  wire logic [1:0]               dl1_data_ce,
  input  wire logic [1:0]               dl1_data_raw_ue,
  // L2 cache error events
  input  wire logic [3:0]               l2_tag_ce,
  input  wire logic [3:0]               l2_tag_ue,
  input  wire logic [3:0]               l2_data_ce,
  input  wire logic [3:0]               l2_data_raw_ue,
  // L2 control
  input  wire logic                     l2_reduction_defer,
  input  wire logic                     l2_inval_done,
  // Set-assoc TLB parity events
  input  wire logic [1:0]               itlb_sa_perr,
  input  wire logic [1:0]               dtlb_sa_perr,
  // Diagnostic alternate-space loads
  input  wire logic                     itlb_diag_rd,
  input  wire logic                     itlb_diag_perr,
  input  wire logic                     dtlb_diag_rd,
  input  wire logic                     dtlb_diag_perr,
  input  wire logic                     urgent_clr,
  // Fully-assoc TLB lookup, instr and data
  input  wire logic [FA_ENTRIES-1:0]    fa_itlb_raw_match,
  input  wire logic [FA_ENTRIES-1:0]    fa_itlb_tag_perr,
  input  wire logic [FA_ENTRIES-1:0]    fa_itlb_data_perr,
  input  wire logic                     fa_itlb_lookup,
  input  wire logic [FA_ENTRIES-1:0]    fa_dtlb_raw_match,
  input  wire logic [FA_ENTRIES-1:0]    fa_dtlb_tag_perr,
  input  wire logic [FA_ENTRIES-1:0]    fa_dtlb_data_perr,
  input  wire logic                     fa_dtlb_lookup,
  input  wire logic [3*FA_ENTRIES-1:0]  fa_lock_copies,
  input  wire logic                     fault_clr,
  // Way status and actions
  output logic [1:0]                    il1_way_active,
  output logic [1:0]                    dl1_way_active,
  output logic [3:0]                    l2_way_active,
  output logic [1:0]                    tlb_way_active,
  output logic [1:0]                    il1_inval_way,
  output logic [1:0]                    dl1_inval_wb_way,
  output logic                          l2_inval_all,
  output logic [1:0]                    tlb_inval_way,
  output logic                          tlb_demap_req,
  output logic                          halt_error_state,
  output logic                          way_degrade_flag,
  // Urgent and fault status
  output logic                          instr_tlb_urgent_bit,
  output logic                          data_tlb_urgent_bit,
  output logic [FA_ENTRIES-1:0]         fa_itlb_hit,
  output logic [FA_ENTRIES-1:0]         fa_dtlb_hit,
  output logic [FA_ENTRIES-1:0]         fa_lock,
  output logic                          instr_access_err,
  output logic                          data_access_err,
  output logic                          ifsr_perr,
  output logic [`CWD_IDX_W-1:0]         ifsr_index,
  output logic                          dfsr_perr,
  output logic [`CWD_IDX_W-1:0]         dfsr_index
);

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  logic [31:0] tick_cnt_reg;
  logic        interval_end;
  assign interval_end = (tick_cnt_reg == 32'(INTERVAL_CYC - 1));

  // Free-running sampling interval; end pulse clears all tallies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'h0;
    end else if (ce) begin
      tick_cnt_reg <= interval_end ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  // ****************************************************************
  // Per-way tallies
  // ****************************************************************
  // Saturating add of up to four events; a pending hit forces nothing here
  function automatic logic [CNT_W-1:0] tally(input logic [CNT_W-1:0] c, input logic [2:0] n);
    logic [CNT_W:0] s;
    s = {1'b0, c} + (CNT_W+1)'(n);
    tally = s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
  endfunction

  // Ways 0-1 I1, 2-3 D1, 4-7 L2, 8-9 ITLB, 10-11 DTLB
  localparam int NW = 12;
  logic [2:0]       ev_n [NW];
  logic [CNT_W-1:0] cnt_reg [NW];
  logic [NW-1:0]    over;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ev_n[i]    = 3'(il1_tag_perr[i]) + 3'(il1_data_perr[i]);
      ev_n[2+i]  = 3'(dl1_tag_perr[i]) + 3'(dl1_data_ce[i]) + 3'(dl1_data_raw_ue[i]);
      ev_n[8+i]  = 3'(itlb_sa_perr[i]);
      ev_n[10+i] = 3'(dtlb_sa_perr[i]);
    end
    for (int i = 0; i < 4; i++) begin
      ev_n[4+i] = 3'(l2_tag_ce[i]) + 3'(l2_tag_ue[i]) + 3'(l2_data_ce[i]) + 3'(l2_data_raw_ue[i]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NW; g++) begin : g_cnt
      // Counter restarts each interval so it measures a rate
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_reg[g] <= '0;
        end else if (ce) begin
          cnt_reg[g] <= (interval_end || over[g]) ? '0 : tally(cnt_reg[g], ev_n[g]);
        end
      end
      assign over[g] = (cnt_reg[g] > THRESHOLD);
    end
  endgenerate

  // ****************************************************************
  // L1 reduction
  // ****************************************************************
  logic [1:0] il1_hit;
  logic [1:0] dl1_hit;
  assign il1_hit = over[1:0] & il1_way_active;
  assign dl1_hit = over[3:2] & dl1_way_active;

  // Last active L1 way cannot be retired: the core must halt instead
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      il1_way_active   <= 2'h3;
      dl1_way_active   <= 2'h3;
      il1_inval_way    <= 2'h0;
      dl1_inval_wb_way <= 2'h0;
      halt_error_state <= 1'b0;
    end else if (ce) begin
      il1_inval_way    <= 2'h0;
      dl1_inval_wb_way <= 2'h0;
      if (il1_hit != 2'h0) begin
        if ($countones(il1_way_active) == 1) begin
          halt_error_state <= 1'b1;
        end else begin
          il1_way_active <= il1_way_active & ~il1_hit;
          il1_inval_way  <= il1_hit;
        end
      end
      if (dl1_hit != 2'h0) begin
        if ($countones(dl1_way_active) == 1) begin
          halt_error_state <= 1'b1;
        end else begin
          dl1_way_active   <= dl1_way_active & ~dl1_hit;
          dl1_inval_wb_way <= dl1_hit;
        end
      end
    end
  end

  // ****************************************************************
  // L2 reduction with defer
  // ****************************************************************
  cwd_l2_state_t l2_state_reg;
  logic [3:0]    l2_pend_reg;
  logic [3:0]    l2_hit;
  assign l2_hit = over[7:4] & l2_way_active;

  // Pending way latches the hits seen in idle; the sweep waits for the invalidate to finish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l2_state_reg  <= CWD_L2_IDLE;
      l2_pend_reg   <= 4'h0;
      l2_way_active <= 4'hF;
      l2_inval_all  <= 1'b0;
    end else if (ce) begin
      l2_inval_all <= 1'b0;
      case (l2_state_reg)
        CWD_L2_IDLE: begin
          if (l2_hit != 4'h0) begin
            l2_pend_reg  <= l2_hit;
            l2_state_reg <= l2_reduction_defer ? CWD_L2_PEND : CWD_L2_RUN;
            l2_inval_all <= !l2_reduction_defer;
          end
        end
        CWD_L2_PEND: begin
          if (!l2_reduction_defer) begin
            l2_state_reg <= CWD_L2_RUN;
            l2_inval_all <= 1'b1;
          end
        end
        CWD_L2_RUN: begin
          if (l2_inval_done) begin
            if ($countones(l2_way_active) > 1) begin
              l2_way_active <= l2_way_active & ~l2_pend_reg;
            end                                              // last way stays
            l2_pend_reg  <= 4'h0;
            l2_state_reg <= CWD_L2_IDLE;
          end
        end
        default: l2_state_reg <= CWD_L2_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Set-assoc TLB reduction
  // ****************************************************************
  logic [1:0] tlb_hit;
  assign tlb_hit = over[9:8] | over[11:10];

  // Reduction always happens; a lone survivor first gets its partner back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tlb_way_active <= 2'h3;
      tlb_inval_way  <= 2'h0;
    end else if (ce) begin
      tlb_inval_way <= tlb_hit;
      if (tlb_hit != 2'h0) begin
        tlb_way_active <= 2'h3 & ~tlb_hit;
      end
    end
  end

  // Way-degrade flag, sticky until reset; set on every reduction that retires or sweeps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      way_degrade_flag <= 1'b0;
    end else if (ce) begin
      if ((il1_hit != 2'h0 && $countones(il1_way_active) > 1) ||
          (dl1_hit != 2'h0 && $countones(dl1_way_active) > 1) ||
          (l2_state_reg == CWD_L2_RUN && l2_inval_done) || tlb_hit != 2'h0) begin
        way_degrade_flag <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // TLB entry parity
  // ****************************************************************
  // Lock bit voted from three copies; no error is ever flagged on it
  generate
    for (g = 0; g < FA_ENTRIES; g++) begin : g_fa
      logic [2:0] cp;
      assign cp = fa_lock_copies[3*g +: 3];
      assign fa_lock[g] = (cp[0] & cp[1]) | (cp[1] & cp[2]) | (cp[0] & cp[2]);
    end
  endgenerate

  // Bad tag parity masks the match, locked or not
  assign fa_itlb_hit = fa_itlb_raw_match & ~fa_itlb_tag_perr;
  assign fa_dtlb_hit = fa_dtlb_raw_match & ~fa_dtlb_tag_perr;

  logic [FA_ENTRIES-1:0] fa_ierr;
  logic [FA_ENTRIES-1:0] fa_derr;
  assign fa_ierr = fa_itlb_lookup ? (fa_itlb_hit & fa_itlb_data_perr) : '0;
  assign fa_derr = fa_dtlb_lookup ? (fa_dtlb_hit & fa_dtlb_data_perr) : '0;

  // Lowest erring entry index
  function automatic logic [`CWD_IDX_W-1:0] first_idx(input logic [FA_ENTRIES-1:0] v);
    first_idx = '0;
    for (int i = FA_ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) first_idx = `CWD_IDX_W'(i);
    end
  endfunction

  // Precise faults with entry index; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_access_err <= 1'b0;
      data_access_err  <= 1'b0;
      ifsr_perr        <= 1'b0;
      ifsr_index       <= '0;
      dfsr_perr        <= 1'b0;
      dfsr_index       <= '0;
    end else if (ce) begin
      instr_access_err <= |fa_ierr;
      data_access_err  <= |fa_derr;
      if (|fa_ierr) begin
        ifsr_perr  <= 1'b1;
        ifsr_index <= first_idx(fa_ierr);
      end else if (fault_clr) begin
        ifsr_perr <= 1'b0;
      end
      if (|fa_derr) begin
        dfsr_perr  <= 1'b1;
        dfsr_index <= first_idx(fa_derr);
      end else if (fault_clr) begin
        dfsr_perr <= 1'b0;
      end
    end
  end

  // Diagnostic reads raise urgent bits; translation errors only demap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_tlb_urgent_bit <= 1'b0;
      data_tlb_urgent_bit  <= 1'b0;
      tlb_demap_req        <= 1'b0;
    end else if (ce) begin
      tlb_demap_req <= (itlb_diag_rd & itlb_diag_perr) | (dtlb_diag_rd & dtlb_diag_perr) |
                       (|itlb_sa_perr) | (|dtlb_sa_perr);
      if (dtlb_diag_rd && dtlb_diag_perr) data_tlb_urgent_bit <= 1'b1;
      else if (urgent_clr) data_tlb_urgent_bit <= 1'b0;
      if (itlb_diag_rd && itlb_diag_perr) instr_tlb_urgent_bit <= 1'b1;
      else if (urgent_clr) instr_tlb_urgent_bit <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  il1_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && il1_hit != 2'h0 && $countones(il1_way_active) == 1 |=> halt_error_state)
    else $error("I1 last way did not halt");
  il1_retire_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && il1_hit == 2'h1 && il1_way_active == 2'h3 |=> il1_way_active == 2'h2 && il1_inval_way == 2'h1)
    else $error("I1 way not retired");
  dl1_retire_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && dl1_hit == 2'h2 && dl1_way_active == 2'h3 |=> dl1_way_active == 2'h1 && way_degrade_flag)
    else $error("D1 way not retired");
  l2_defer_a: assert property (@(posedge clk) disable iff (!rst_n)
    l2_state_reg == CWD_L2_PEND && l2_reduction_defer |=> !l2_inval_all)
    else $error("L2 sweep started while deferred");
  l2_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && l2_state_reg == CWD_L2_IDLE && l2_hit != 4'h0 && !l2_reduction_defer |=> l2_inval_all)
    else $error("L2 sweep not started");
  l2_last_way_a: assert property (@(posedge clk) disable iff (!rst_n)
    $countones(l2_way_active) == 1 |=> $countones(l2_way_active) == 1)
    else $error("Last L2 way lost");
  itlb_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && fa_itlb_lookup && (fa_itlb_raw_match & ~fa_itlb_tag_perr & fa_itlb_data_perr) != '0
    |=> instr_access_err && ifsr_perr)
    else $error("Fully-assoc instr fault missing");
  urgent_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && dtlb_diag_rd && dtlb_diag_perr |=> data_tlb_urgent_bit && tlb_demap_req)
    else $error("DTLB urgent bit not set");

endmodule // cwd_way_degrade

// *** test_cwd_way_degrade.sv ***
// Self-checking testbench for the cache and TLB way-degrade block
`timescale 1ns/100ps
`include "cwd_consts.svh"

module test_cwd_way_degrade;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst_n, ce;
  logic [1:0]  il1_tag_perr, il1_data_perr, dl1_tag_perr, dl1_data_ce, dl1_data_raw_ue, itlb_sa_perr, dtlb_sa_perr;
  logic [3:0]  l2_tag_ce, l2_tag_ue, l2_data_ce, l2_data_raw_ue, l2_way_active;
  logic        l2_reduction_defer, l2_inval_done, itlb_diag_rd, itlb_diag_perr, dtlb_diag_rd, dtlb_diag_perr;
  logic        urgent_clr, fa_itlb_lookup, fa_dtlb_lookup, fault_clr;
  logic [31:0] fa_itlb_raw_match, fa_itlb_tag_perr, fa_itlb_data_perr, fa_itlb_hit, fa_lock;
  logic [31:0] fa_dtlb_raw_match, fa_dtlb_tag_perr, fa_dtlb_data_perr, fa_dtlb_hit;
  logic [95:0] fa_lock_copies;
  logic [1:0]  il1_way_active, dl1_way_active, tlb_way_active, il1_inval_way, dl1_inval_wb_way, tlb_inval_way;
  logic        l2_inval_all, tlb_demap_req, halt_error_state, way_degrade_flag, instr_tlb_urgent_bit;
  logic        data_tlb_urgent_bit, instr_access_err, data_access_err, ifsr_perr, dfsr_perr;
  logic [4:0]  ifsr_index, dfsr_index;
  logic [1:0]  il1_cap, dl1_cap, tlb_cap;
  int          err_count, n_checks, n_all, n_demap, n_iae, n_dae;

  // Short interval and low threshold keep the run brief
  cwd_way_degrade #(.CNT_W(8), .THRESHOLD(8'h02), .INTERVAL_CYC(64), .FA_ENTRIES(32)) dut (
    .clk, .rst_n, .ce, .il1_tag_perr, .il1_data_perr, .dl1_tag_perr, .dl1_data_ce, .dl1_data_raw_ue,
    .l2_tag_ce, .l2_tag_ue, .l2_data_ce, .l2_data_raw_ue, .l2_reduction_defer, .l2_inval_done,
    .itlb_sa_perr, .dtlb_sa_perr, .itlb_diag_rd, .itlb_diag_perr, .dtlb_diag_rd, .dtlb_diag_perr,
    .urgent_clr, .fa_itlb_raw_match, .fa_itlb_tag_perr, .fa_itlb_data_perr, .fa_itlb_lookup,
    .fa_dtlb_raw_match, .fa_dtlb_tag_perr, .fa_dtlb_data_perr, .fa_dtlb_lookup, .fa_lock_copies,
    .fault_clr, .il1_way_active, .dl1_way_active, .l2_way_active, .tlb_way_active, .il1_inval_way,
    .dl1_inval_wb_way, .l2_inval_all, .tlb_inval_way, .tlb_demap_req, .halt_error_state,
    .way_degrade_flag, .instr_tlb_urgent_bit, .data_tlb_urgent_bit, .fa_itlb_hit, .fa_dtlb_hit,
    .fa_lock, .instr_access_err, .data_access_err, .ifsr_perr, .ifsr_index, .dfsr_perr, .dfsr_index);

  cwd_l2_sweep_model #(.SWEEP_CYC(12)) l2_model (.clk, .rst_n, .l2_inval_all, .l2_inval_done);

  // ****************************************
  // Clock, pulse capture, helpers
  // ****************************************
  always #2 clk = ~clk;

  // Pulses are captured so checks do not hang on the exact cycle
  always @(posedge clk) begin
    il1_cap = il1_cap | il1_inval_way;
    dl1_cap = dl1_cap | dl1_inval_wb_way;
    tlb_cap = tlb_cap | tlb_inval_way;
    if (l2_inval_all === 1'b1) n_all++;
    if (tlb_demap_req === 1'b1) n_demap++;
    if (instr_access_err === 1'b1) n_iae++;
    if (data_access_err === 1'b1) n_dae++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Next falling edge, then drop every event strobe
  task step;
    @(negedge clk);
    {il1_tag_perr, il1_data_perr, dl1_tag_perr, dl1_data_ce, dl1_data_raw_ue, itlb_sa_perr, dtlb_sa_perr} = '0;
    {l2_tag_ce, l2_tag_ue, l2_data_ce, l2_data_raw_ue} = '0;
    {itlb_diag_rd, itlb_diag_perr, dtlb_diag_rd, dtlb_diag_perr, urgent_clr, fault_clr} = '0;
    {fa_itlb_lookup, fa_dtlb_lookup} = '0;
  endtask

  task do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    {l2_reduction_defer, fa_itlb_raw_match, fa_itlb_tag_perr, fa_itlb_data_perr} = '0;
    {fa_dtlb_raw_match, fa_dtlb_tag_perr, fa_dtlb_data_perr, fa_lock_copies} = '0;
    {il1_cap, dl1_cap, tlb_cap, n_all, n_demap, n_iae, n_dae} = '0;
    repeat (20) step;
    rst_n = 1'b1;
  endtask

  task l2_hit(input int w);
    step;
    l2_tag_ce[w] = 1'b1; l2_tag_ue[w] = 1'b1; l2_data_ce[w] = 1'b1; l2_data_raw_ue[w] = 1'b1;
    step;
  endtask

  task test_done;
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_il1;
    do_reset;
    chk({il1_way_active, dl1_way_active, tlb_way_active, l2_way_active}, 32'h3FF);
    chk({halt_error_state, way_degrade_flag}, 32'h0);
    step; il1_tag_perr = 2'b01; il1_data_perr = 2'b01;  // Two classes in one cycle
    step; il1_data_perr = 2'b01;
    step; repeat (3) step;
    chk(il1_cap, 32'h1);
    chk(il1_way_active, 32'h2);
    chk({halt_error_state, way_degrade_flag}, 32'h1);
    step; il1_tag_perr = 2'b10; il1_data_perr = 2'b10;
    step; il1_tag_perr = 2'b10;
    step; repeat (3) step;
    chk(halt_error_state, 32'h1);
  endtask

  task t_dl1;
    do_reset;
    step; dl1_tag_perr = 2'b10; dl1_data_ce = 2'b10;    // At the threshold only
    step; repeat (70) step;
    dl1_data_ce = 2'b10; dl1_data_raw_ue = 2'b10;
    step; repeat (3) step;
    chk({dl1_cap, dl1_way_active}, 32'h3);
    dl1_tag_perr = 2'b10; dl1_data_ce = 2'b10; dl1_data_raw_ue = 2'b10;
    step; repeat (3) step;
    chk({dl1_cap, dl1_way_active}, 32'h9);
    chk({halt_error_state, way_degrade_flag}, 32'h1);
    dl1_tag_perr = 2'b01; dl1_data_ce = 2'b01; dl1_data_raw_ue = 2'b01;
    step; repeat (3) step;
    chk(halt_error_state, 32'h1);
  endtask

  task t_l2;
    do_reset;
    l2_reduction_defer = 1'b1;
    l2_hit(2);
    repeat (10) step;
    chk({n_all[3:0], l2_way_active, way_degrade_flag}, 32'h1E);
    l2_reduction_defer = 1'b0;
    repeat (30) step;
    chk({n_all[3:0], l2_way_active, way_degrade_flag}, 32'h37);
    l2_hit(0);
    repeat (3) step;
    chk(n_all, 32'h2);
    repeat (30) step;
    l2_hit(1);
    repeat (30) step;
    chk(l2_way_active, 32'h8);
    l2_hit(2);
    repeat (30) step;
    chk(n_all, 32'h3);
    l2_hit(3);
    repeat (30) step;
    chk({n_all[3:0], l2_way_active}, 32'h48);
  endtask

  task t_tlb;
    do_reset;
    step; itlb_sa_perr = 2'b01;
    step; repeat (3) step;
    chk({n_demap[3:0], instr_tlb_urgent_bit, data_tlb_urgent_bit}, 32'h4);
    itlb_sa_perr = 2'b01;
    step; itlb_sa_perr = 2'b01;
    step; repeat (3) step;
    chk({tlb_cap, tlb_way_active, way_degrade_flag}, 32'h0D);
    dtlb_sa_perr = 2'b10;
    step; dtlb_sa_perr = 2'b10;
    step; dtlb_sa_perr = 2'b10;
    step; repeat (3) step;
    chk({tlb_cap, tlb_way_active}, 32'hD);
  endtask

  task t_diag;
    do_reset;
    step; dtlb_diag_rd = 1'b1; dtlb_diag_perr = 1'b1;
    step; repeat (2) step;
    chk({n_demap[3:0], instr_tlb_urgent_bit, data_tlb_urgent_bit}, 32'h5);
    itlb_diag_rd = 1'b1; itlb_diag_perr = 1'b1;
    step; repeat (2) step;
    chk({n_demap[3:0], instr_tlb_urgent_bit, data_tlb_urgent_bit}, 32'hB);
    urgent_clr = 1'b1;
    step; repeat (2) step;
    itlb_diag_rd = 1'b1;                                // Clean read leaves status alone
    step; repeat (2) step;
    chk({n_demap[3:0], instr_tlb_urgent_bit, data_tlb_urgent_bit}, 32'h8);
    ce = 1'b0;                                          // Frozen block must ignore a bad read
    dtlb_diag_rd = 1'b1;
    dtlb_diag_perr = 1'b1;
    step; repeat (2) step;
    chk({n_demap[3:0], instr_tlb_urgent_bit, data_tlb_urgent_bit}, 32'h8);
    ce = 1'b1;
  endtask

  task t_fa;
    do_reset;
    step;
    fa_itlb_raw_match = 32'h0000_00A0; fa_itlb_tag_perr = 32'h0000_0020; fa_itlb_data_perr = 32'h0000_0280;
    fa_lock_copies = 96'h1E3;                           // Votes 1, 0, 1 for entries 0 to 2
    fa_dtlb_raw_match = 32'h0000_0008; fa_dtlb_data_perr = 32'h0000_0010;
    #1;
    chk(fa_itlb_hit, 32'h0000_0080);
    chk(fa_lock, 32'h0000_0005);
    chk(fa_dtlb_hit, 32'h0000_0008);
    step; fa_itlb_lookup = 1'b1; fa_dtlb_lookup = 1'b1;
    step; repeat (2) step;
    chk({n_iae[3:0], ifsr_perr, ifsr_index}, 32'h67);
    chk({n_dae[3:0], dfsr_perr}, 32'h0);
    fa_dtlb_raw_match = 32'h8000_0000; fa_dtlb_data_perr = 32'hC000_0000;
    fa_dtlb_lookup = 1'b1;
    step; repeat (2) step;
    chk({n_dae[3:0], dfsr_perr, dfsr_index}, 32'h7F);
    fault_clr = 1'b1;
    step; repeat (2) step;
    chk({ifsr_perr, dfsr_perr}, 32'h0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {err_count, n_checks} = '0;
    t_il1;
    t_dl1;
    t_l2;
    t_tlb;
    t_diag;
    t_fa;
    test_done;
  end

  // Whole run is well under 1000 cycles; four times that means a hang
  initial begin
    #16000;
    err_count++;
    test_done;
  end
endmodule // test_cwd_way_degrade
